// file: hw/ovp_top.sv
// Four-stage overvoltage pick-up block with APB registers and interrupt.
// Operation
// - Four independent overvoltage stages.
// - Line-line or line-neutral magnitudes selectable.
// - Magnitudes evaluated every 5 ms.
// - Selector: P-P, P-E, channel 3, 4.
// - Two-line wiring uses only two channels.
// - Ch4 always; ch3 only two-line wiring.
// - Force status when global forcing enabled.
// - General settings unaffected by group switch.
// - Ratio of magnitude to threshold computed.
// - Release below 97 percent of threshold.
// - Common threshold, one/two/three voltage vote.
// - Threshold 50.00 to 150.00, default 105.
// - Active group supplies threshold, mode live.
// - Pick-up without block gives start.
//
// Design decisions made here: register access over APB and the register offsets.
module ovp_top
#(
  parameter int unsigned TBASE_CYCLES = ovp_pkg::TBASE_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ovp_pkg::MAGW-1:0] mag_l12,
  input wire logic [ovp_pkg::MAGW-1:0] mag_l23,
  input wire logic [ovp_pkg::MAGW-1:0] mag_l31,
  input wire logic [ovp_pkg::MAGW-1:0] mag_l1,
  input wire logic [ovp_pkg::MAGW-1:0] mag_l2,
  input wire logic [ovp_pkg::MAGW-1:0] mag_l3,
  input wire logic [ovp_pkg::MAGW-1:0] mag_ch3,
  input wire logic [ovp_pkg::MAGW-1:0] mag_ch4,
  input wire logic [3:0] block_in,
  output logic [3:0] start_out,
  output logic [3:0] blocked_out,
  output logic [3:0] trip_out,
  output logic irq
);
  localparam int unsigned NS = ovp_pkg::STAGES;
  localparam int unsigned NG = ovp_pkg::GROUPS;

  logic [31:0] tcnt_ff;
  logic tick_ff;
  logic force_en_ff;
  logic wiring_ff;
  logic grp_ff;
  logic [1:0] sel_ff [NS];
  logic [1:0] force_ff [NS];
  logic [15:0] uset_ff [NG][NS];
  logic [1:0] mode_ff [NG][NS];
  logic [NS-1:0] pick;
  logic [15:0] ratio [NS][3];
  logic [7:0] irq_stat_ff;
  logic [7:0] irq_en_ff;
  logic [NS-1:0] start_q_ff;
  logic [NS-1:0] blk_q_ff;
  logic [NS-1:0] nxt_start;
  logic [NS-1:0] nxt_blocked;
  logic [NS-1:0] nxt_trip;
  logic [7:0] ev_set;
  logic [7:0] clr_mask;
  logic wr_acc;
  logic rd_acc;
  logic hit;
  logic [31:0] rdat;
  logic [ovp_pkg::MAGW-1:0] mag_ll [3];
  logic [ovp_pkg::MAGW-1:0] mag_ln [3];
  logic [1:0] sidx;
  logic sgrp;
  logic [1:0] ridx;
  logic [15:0] wval;

  assign mag_ll[0] = mag_l12;
  assign mag_ll[1] = mag_l23;
  assign mag_ll[2] = mag_l31;
  assign mag_ln[0] = mag_l1;
  assign mag_ln[1] = mag_l2;
  assign mag_ln[2] = mag_l3;

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  assign sidx = paddr[3:2];
  assign sgrp = paddr[4];
  assign ridx = paddr[5:4];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tcnt_ff <= 32'h0;
      tick_ff <= 1'b0;
    end
    else if (tcnt_ff >= TBASE_CYCLES - 1)
    begin
      tcnt_ff <= 32'h0;
      tick_ff <= 1'b1;
    end
    else
    begin
      tcnt_ff <= tcnt_ff + 32'h1;
      tick_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      force_en_ff <= 1'b0;
      wiring_ff <= 1'b0;
      grp_ff <= 1'b0;
    end
    else if (wr_acc && paddr == ovp_pkg::A_GLOBAL)
    begin
      force_en_ff <= pwdata[ovp_pkg::GBL_FORCE_EN];
      wiring_ff <= pwdata[ovp_pkg::GBL_WIRING];
      grp_ff <= pwdata[ovp_pkg::GBL_GROUP];
    end
  end

  // A threshold write outside the settable range is clamped to its bound.
  always_comb
  begin
    wval = pwdata[15:0];
    if (wval < ovp_pkg::USET_MIN)
    begin
      wval = ovp_pkg::USET_MIN;
    end
    else if (wval > ovp_pkg::USET_MAX)
    begin
      wval = ovp_pkg::USET_MAX;
    end
  end

  genvar s;
  generate
    for (s = 0; s < NS; s++)
    begin : g_stage
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sel_ff[s] <= ovp_pkg::SEL_RST;
          force_ff[s] <= ovp_pkg::FORCE_RST;
        end
        else if (wr_acc && paddr[11:4] == ovp_pkg::A_STAGE_BASE[11:4] && sidx == 2'(s))
        begin
          sel_ff[s] <= pwdata[ovp_pkg::GEN_SEL_LSB +: 2];
          force_ff[s] <= pwdata[ovp_pkg::GEN_FORCE_LSB +: 2];
        end
      end
      for (genvar k = 0; k < NG; k++)
      begin : g_grp
        always_ff @(posedge pclk or negedge presetn)
        begin
          if (!presetn)
          begin
            uset_ff[k][s] <= ovp_pkg::USET_RST;
            mode_ff[k][s] <= ovp_pkg::MODE_RST;
          end
          else if (wr_acc && paddr[11:5] == ovp_pkg::A_GRP_BASE[11:5] && sidx == 2'(s)
                   && sgrp == 1'(k))
          begin
            uset_ff[k][s] <= wval;
            mode_ff[k][s] <= (pwdata[17:16] == 2'h0) ? 2'h1 : pwdata[17:16];
          end
        end
      end
      ovp_stage u_stage
      (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick_ff),
        .wiring_2ll(wiring_ff),
        .mag_ll(mag_ll),
        .mag_ln(mag_ln),
        .mag_ch3(mag_ch3),
        .mag_ch4(mag_ch4),
        .sel(sel_ff[s]),
        .mode(mode_ff[grp_ff][s]),
        .uset(uset_ff[grp_ff][s]),
        .pickup(pick[s]),
        .ratio(ratio[s])
      );
      always_comb
      begin
        nxt_start[s] = 1'b0;
        nxt_blocked[s] = 1'b0;
        nxt_trip[s] = 1'b0;
        if (force_en_ff && force_ff[s] != ovp_pkg::OVP_FRC_NORMAL)
        begin
          nxt_start[s] = (force_ff[s] == ovp_pkg::OVP_FRC_START)
                         || (force_ff[s] == ovp_pkg::OVP_FRC_TRIP);
          nxt_trip[s] = (force_ff[s] == ovp_pkg::OVP_FRC_TRIP);
          nxt_blocked[s] = (force_ff[s] == ovp_pkg::OVP_FRC_BLOCKED);
        end
        else if (pick[s])
        begin
          nxt_start[s] = !block_in[s];
          nxt_blocked[s] = block_in[s];
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_out <= 4'h0;
      blocked_out <= 4'h0;
      trip_out <= 4'h0;
      start_q_ff <= 4'h0;
      blk_q_ff <= 4'h0;
    end
    else
    begin
      start_out <= nxt_start;
      blocked_out <= nxt_blocked;
      trip_out <= nxt_trip;
      start_q_ff <= start_out;
      blk_q_ff <= blocked_out;
    end
  end

  // Rising edges of start and blocked are the interrupt events.
  assign ev_set = {blocked_out & ~blk_q_ff, start_out & ~start_q_ff};
  assign clr_mask = (wr_acc && paddr == ovp_pkg::A_IRQ_CLR) ? pwdata[7:0] : 8'h00;

  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_ff <= 8'h00;
    end
    else
    begin
      irq_stat_ff <= (irq_stat_ff & ~clr_mask) | ev_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_en_ff <= 8'h00;
      irq <= 1'b0;
    end
    else
    begin
      if (wr_acc && paddr == ovp_pkg::A_IRQ_EN)
      begin
        irq_en_ff <= pwdata[7:0];
      end
      irq <= |(((irq_stat_ff & ~clr_mask) | ev_set) & irq_en_ff);
    end
  end

  always_comb
  begin
    rdat = 32'h0;
    hit = 1'b1;
    if (paddr == ovp_pkg::A_GLOBAL)
    begin
      rdat = {29'h0, grp_ff, wiring_ff, force_en_ff};
    end
    else if (paddr == ovp_pkg::A_IRQ_STAT)
    begin
      rdat = {24'h0, irq_stat_ff};
    end
    else if (paddr == ovp_pkg::A_IRQ_EN)
    begin
      rdat = {24'h0, irq_en_ff};
    end
    else if (paddr == ovp_pkg::A_IRQ_CLR)
    begin
      rdat = 32'h0;
    end
    else if (paddr == ovp_pkg::A_STATUS)
    begin
      rdat = {16'h0, pick, trip_out, blocked_out, start_out};
    end
    else if (paddr[11:4] == ovp_pkg::A_STAGE_BASE[11:4])
    begin
      rdat = {26'h0, force_ff[sidx], 2'h0, sel_ff[sidx]};
    end
    else if (paddr[11:5] == ovp_pkg::A_GRP_BASE[11:5])
    begin
      rdat = {14'h0, mode_ff[sgrp][sidx], uset_ff[sgrp][sidx]};
    end
    else if (paddr[11:6] == ovp_pkg::A_RATIO_BASE[11:6] && paddr[3:2] != 2'h3)
    begin
      rdat = {16'h0, ratio[ridx][paddr[3:2]]};
    end
    else
    begin
      hit = 1'b0;
    end
  end

  // Reads are latched in setup so the access phase always completes at once.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      if (rd_acc)
      begin
        prdata <= rdat;
      end
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
    end
  end
endmodule

// file: inc/ovp_pkg.sv
// Shared constants, register map and types for the overvoltage pick-up block.
package ovp_pkg;
  localparam int unsigned STAGES = 4;
  localparam int unsigned GROUPS = 2;
  localparam int unsigned MAGW = 16;
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned TBASE_US = 5000;
  localparam int unsigned TBASE_CYC = (TBASE_US * 1000) / CLK_NS;
  localparam logic [15:0] USET_MIN = 16'h1388;
  localparam logic [15:0] USET_MAX = 16'h3a98;
  localparam logic [15:0] USET_RST = 16'h2904;
  localparam logic [6:0] RESET_PCT = 7'h61;
  localparam logic [6:0] FULL_PCT = 7'h64;
  localparam logic [11:0] A_GLOBAL = 12'h000;
  localparam logic [11:0] A_IRQ_STAT = 12'h004;
  localparam logic [11:0] A_IRQ_EN = 12'h008;
  localparam logic [11:0] A_IRQ_CLR = 12'h00c;
  localparam logic [11:0] A_STATUS = 12'h010;
  localparam logic [11:0] A_STAGE_BASE = 12'h100;
  localparam logic [11:0] A_GRP_BASE = 12'h200;
  localparam logic [11:0] A_RATIO_BASE = 12'h300;
  localparam int unsigned GEN_SEL_LSB = 0;
  localparam int unsigned GEN_FORCE_LSB = 4;
  localparam int unsigned GBL_FORCE_EN = 0;
  localparam int unsigned GBL_WIRING = 1;
  localparam int unsigned GBL_GROUP = 2;
  localparam int unsigned GRP_MODE_LSB = 16;
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic [1:0] FORCE_RST = 2'h0;
  localparam logic [1:0] MODE_RST = 2'h1;
  typedef enum logic [1:0] {
    OVP_SEL_PP = 2'b00,
    OVP_SEL_PE = 2'b01,
    OVP_SEL_CH3 = 2'b10,
    OVP_SEL_CH4 = 2'b11
  } ovp_sel_e;
  typedef enum logic [1:0] {
    OVP_FRC_NORMAL = 2'b00,
    OVP_FRC_START = 2'b01,
    OVP_FRC_TRIP = 2'b10,
    OVP_FRC_BLOCKED = 2'b11
  } ovp_force_e;
endpackage

// file: hw/ovp_stage.sv
// One overvoltage stage: channel selection, threshold compare with hysteresis, vote.
module ovp_stage
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic wiring_2ll,
  input wire logic [ovp_pkg::MAGW-1:0] mag_ll [3],
  input wire logic [ovp_pkg::MAGW-1:0] mag_ln [3],
  input wire logic [ovp_pkg::MAGW-1:0] mag_ch3,
  input wire logic [ovp_pkg::MAGW-1:0] mag_ch4,
  input wire logic [1:0] sel,
  input wire logic [1:0] mode,
  input wire logic [15:0] uset,
  output logic pickup,
  output logic [15:0] ratio [3]
);
  logic [ovp_pkg::MAGW-1:0] m [3];
  logic [2:0] over_ff;
  logic [2:0] nxt_over;
  logic [1:0] cnt;
  logic [1:0] need;
  logic [31:0] lhs [3];
  logic [31:0] rhs_set;
  logic [31:0] rhs_rst;

  // Two-line wiring leaves the third phase slot unused.
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      m[i] = '0;
    end
    if (sel == ovp_pkg::OVP_SEL_PP || sel == ovp_pkg::OVP_SEL_PE)
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (!(wiring_2ll && i == 2))
        begin
          m[i] = (sel == ovp_pkg::OVP_SEL_PP) ? mag_ll[i] : mag_ln[i];
        end
      end
    end
    else if (sel == ovp_pkg::OVP_SEL_CH4)
    begin
      m[0] = mag_ch4;
    end
    else if (wiring_2ll)
    begin
      m[0] = mag_ch3;
    end
  end

  // Magnitudes are per-unit scaled by 10000 like the threshold, so no divide is needed.
  assign rhs_set = {16'h0000, uset} * 32'(ovp_pkg::FULL_PCT);
  assign rhs_rst = {16'h0000, uset} * 32'(ovp_pkg::RESET_PCT);

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_ch
      assign lhs[g] = {16'h0000, m[g]} * 32'(ovp_pkg::FULL_PCT);
      assign nxt_over[g] = over_ff[g] ? (lhs[g] >= rhs_rst) : (lhs[g] > rhs_set);
      // Ratio in hundredths; the divider is costly but runs once per tick.
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          ratio[g] <= 16'h0000;
        end
        else if (tick)
        begin
          ratio[g] <= (uset == 16'h0000) ? 16'hffff : 16'(({16'h0000, m[g]} * 32'h64) / uset);
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      over_ff <= 3'h0;
    end
    else if (tick)
    begin
      over_ff <= nxt_over;
    end
  end

  assign cnt = 2'(over_ff[0]) + 2'(over_ff[1]) + 2'(over_ff[2]);
  assign need = (mode == 2'h0) ? 2'h1 : mode;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pickup <= 1'b0;
    end
    else
    begin
      pickup <= (cnt >= need);
    end
  end
endmodule

// file: bench/ovp_props.sv
// Port-level assertions for the overvoltage pick-up block.
module ovp_props
#(
  parameter int unsigned TBASE_CYCLES = 10
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] start_out,
  input wire logic [3:0] blocked_out,
  input wire logic [3:0] trip_out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_rd_setup;
    psel && !penable && !pwrite;
  endsequence
  chk_ready_after_setup: assert property (s_setup |=> s_access ##0 pready)
    else $error("Ready did not follow a setup cycle.");
  chk_ready_in_access: assert property (pready |-> s_access)
    else $error("Ready outside an access cycle.");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("Ready stood longer than one cycle.");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("Error response without ready.");
  chk_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("Refused read returned nonzero data.");
  chk_rdata_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("Read data changed without a read setup.");
  chk_start_not_blocked: assert property ((start_out & blocked_out) == 4'h0)
    else $error("Stage shows start and blocked together.");
  chk_trip_has_start: assert property ((trip_out & ~start_out) == 4'h0)
    else $error("Trip shown without start.");
endmodule

bind ovp_top ovp_props #(.TBASE_CYCLES(TBASE_CYCLES)) u_props
(
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .start_out(start_out),
  .blocked_out(blocked_out),
  .trip_out(trip_out)
);

// file: bench/tb_top.sv
// Self-checking bench for the overvoltage pick-up block.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned TB = 10;
  localparam logic [15:0] LO = 16'h2710;
  localparam logic [15:0] HI = 16'h2af8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] m [8] = '{default: LO};
  logic [3:0] block_in = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] start_out;
  logic [3:0] blocked_out;
  logic [3:0] trip_out;
  logic irq;
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int checks_done = 0;
  // Rows: l12, l23, l31, l1, l2, l3, ch3, ch4, expected start per stage.
  logic [131:0] rows [9] = '{
    {LO, LO, LO, LO, LO, LO, LO, LO, 4'h0},
    {16'h2904, LO, LO, LO, LO, LO, LO, LO, 4'h0},
    {16'h2905, LO, LO, LO, LO, LO, LO, LO, 4'h1},
    {16'h27c9, LO, LO, LO, LO, LO, LO, LO, 4'h1},
    {16'h27c8, LO, LO, LO, LO, LO, LO, LO, 4'h0},
    {HI, HI, LO, LO, LO, LO, LO, LO, 4'h3},
    {HI, HI, LO, LO, LO, LO, LO, HI, 4'h7},
    {HI, HI, LO, HI, HI, HI, LO, HI, 4'hf},
    {LO, LO, LO, HI, HI, LO, HI, LO, 4'h0}};

  ovp_top #(.TBASE_CYCLES(TB)) DUT
  (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .mag_l12(m[0]),
    .mag_l23(m[1]),
    .mag_l31(m[2]),
    .mag_l1(m[3]),
    .mag_l2(m[4]),
    .mag_l3(m[5]),
    .mag_ch3(m[6]),
    .mag_ch4(m[7]),
    .block_in(block_in),
    .start_out(start_out),
    .blocked_out(blocked_out),
    .trip_out(trip_out),
    .irq(irq)
  );

  always #5 pclk = ~pclk;

  task automatic cmp32(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp4(input string n, input logic [3:0] e, input logic [3:0] g);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // Called just after a rising edge; ends one idle cycle after the answer.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No timeout here; only the watchdog ends a wait that never sees ready.
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp32(n, e, rd);
  endtask

  // One time-base period plus the compare, vote and output register stages.
  task automatic settle;
    repeat (TB + 4) @(posedge pclk);
  endtask

  task automatic print_verdict;
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, 12'h204, 32'h00022904);
    apb(1'b1, 12'h108, 32'h3);
    apb(1'b1, 12'h10c, 32'h1);
    apb(1'b1, 12'h20c, 32'h00032904);
    for (int i = 0; i < 9; i++)
    begin
      for (int j = 0; j < 8; j++)
        m[j] <= rows[i][4 + 16 * (7 - j) +: 16];
      settle();
      cmp4("start_out", rows[i][3:0], start_out);
      if (i == 1)
        rdchk("ratio", 12'h300, 32'h64);
    end
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk("group0", 12'h204, 32'h00012904);
    rdchk("general", 12'h108, 32'h0);
    rdchk("global", 12'h000, 32'h0);
    rdchk("unmapped", 12'hffc, 32'h0);
    cmp4("slverr", 4'h1, {3'h0, err});
    apb(1'b1, 12'h200, 32'h00010001);
    rdchk("clamp_lo", 12'h200, 32'h00011388);
    apb(1'b1, 12'h200, 32'h0001ffff);
    rdchk("clamp_hi", 12'h200, 32'h00013a98);
    apb(1'b1, 12'h200, 32'h00002904);
    rdchk("mode_zero", 12'h200, 32'h00012904);
    apb(1'b1, 12'h210, 32'h00012af8);
    apb(1'b1, 12'h104, 32'h2);
    m[0] <= 16'h2968;
    settle();
    cmp4("group0", 4'hd, start_out);
    apb(1'b1, 12'h000, 32'h4);
    settle();
    cmp4("group1", 4'hc, start_out);
    rdchk("general", 12'h104, 32'h2);
    m[0] <= LO;
    m[2] <= HI;
    m[6] <= HI;
    settle();
    cmp4("no_wiring", 4'hc, start_out);
    apb(1'b1, 12'h000, 32'h6);
    settle();
    cmp4("wiring", 4'h2, start_out);
    m[2] <= LO;
    m[6] <= LO;
    apb(1'b1, 12'h100, 32'h20);
    apb(1'b1, 12'h000, 32'h0);
    settle();
    cmp4("no_force", 4'h0, trip_out);
    apb(1'b1, 12'h000, 32'h1);
    settle();
    cmp4("trip", 4'h1, trip_out);
    cmp4("start", 4'h1, start_out);
    apb(1'b1, 12'h100, 32'h10);
    settle();
    cmp4("force_start", 4'h0, trip_out);
    cmp4("force_start", 4'h1, start_out);
    apb(1'b1, 12'h100, 32'h30);
    settle();
    cmp4("blocked", 4'h1, blocked_out);
    apb(1'b1, 12'h100, 32'h0);
    settle();
    apb(1'b1, 12'h00c, 32'hff);
    apb(1'b1, 12'h008, 32'h1);
    block_in[2] <= 1'b1;
    m[0] <= HI;
    settle();
    cmp4("start", 4'h9, start_out);
    cmp4("blocked", 4'h4, blocked_out);
    cmp4("irq", 4'h1, {3'h0, irq});
    rdchk("irq_stat", 12'h004, 32'h49);
    m[0] <= LO;
    apb(1'b1, 12'h00c, 32'h1);
    settle();
    cmp4("irq", 4'h0, {3'h0, irq});
    apb(1'b1, 12'h008, 32'h40);
    settle();
    cmp4("irq", 4'h1, {3'h0, irq});
    apb(1'b1, 12'h008, 32'h0);
    settle();
    cmp4("irq", 4'h0, {3'h0, irq});
    print_verdict();
  end

  initial
  begin
    #50us;
    errors++;
    print_verdict();
  end
endmodule
